// file: core/wlt_pkg.sv
/*
  Constants, types and decode functions for the second mode register
  link: field layout, command select code, bus offsets, timing counts.
  Assumes one 10 MHz clock shared by both ends of the link.
*/
package wlt_pkg;
  localparam int          ADDR_W     = 18;
  localparam int          TERM_LSB   = 9;
  localparam int          SRT_LSB    = 6;
  localparam int          CAS_LSB    = 3;
  localparam logic [17:0] RSVD_MASK  = 18'h0_0107;
  localparam logic [2:0]  SEL_SECOND = 3'h2;
  localparam logic [3:0]  BURST_CYC  = 4'h4;
  // Controller register byte offsets
  localparam logic [7:0]  OFS_CFG    = 8'h00;
  localparam logic [7:0]  OFS_CMD    = 8'h04;
  localparam logic [7:0]  OFS_LAT    = 8'h08;
  localparam logic [7:0]  OFS_STAT   = 8'h0C;
  // Decoded write termination
  typedef enum logic [2:0] {
    TERM_NONE, TERM_120, TERM_240, TERM_HIZ, TERM_80, TERM_RSVD
  } wlt_term_t;
  // Self-refresh temperature range
  typedef enum logic [1:0] {
    SRT_NORMAL, SRT_REDUCED, SRT_EXTENDED, SRT_AUTO
  } wlt_srt_t;

  // Termination code decode
  function automatic wlt_term_t wlt_term_dec(logic [2:0] code);
    unique case (code)
      3'h0:    return TERM_NONE;
      3'h1:    return TERM_120;
      3'h2:    return TERM_240;
      3'h3:    return TERM_HIZ;
      3'h4:    return TERM_80;
      default: return TERM_RSVD;
    endcase
  endfunction

  // CAS write delay in cycles, zero where not applicable
  function automatic logic [4:0] wlt_cas_dec(logic [2:0] code, logic pre2);
    logic [4:0] d;
    unique case (code)
      3'h0: d = 5'h09;
      3'h1: d = 5'h0A;
      3'h2: d = 5'h0B;
      3'h3: d = 5'h0C;
      3'h4: d = 5'h0E;
      3'h5: d = 5'h10;
      3'h6: d = 5'h12;
      3'h7: d = 5'h14;
    endcase
    return (pre2 && !code[2]) ? 5'h00 : d;
  endfunction

  // Total write delay, whole cycles
  function automatic logic [6:0] wlt_total(logic [4:0] add, logic [3:0] par,
                                           logic [4:0] cas);
    return 7'(add) + 7'(par) + 7'(cas);
  endfunction
endpackage

// file: core/wlt_link_if.sv
/*
  Link between controller and memory device: mode register load
  strobe with select and address, write command, and modes.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface wlt_link_if;
  logic        mrsValid;
  logic [2:0]  mrsSelect;
  logic [17:0] mrsAddr;
  logic        writeCmd;
  logic        writeLeveling;
  logic        preamble2;
  logic [4:0]  addedDelay;
  logic [3:0]  parityDelay;

  modport ctrl (output mrsValid, mrsSelect, mrsAddr, writeCmd,
                writeLeveling, preamble2, addedDelay, parityDelay);
  modport dev  (input  mrsValid, mrsSelect, mrsAddr, writeCmd,
                writeLeveling, preamble2, addedDelay, parityDelay);
endinterface

// file: core/wlt_device.sv
/*
  Device end: holds the second mode register, decodes its fields,
  times each write taken while idle to first data and switches termination.
  Assumes link inputs come from logic on the same clock.
*/
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
module wlt_device (
  input  wire logic                clk,
  input  wire logic                resetn,
  wlt_link_if.dev                  link,
  output wlt_pkg::wlt_term_t       writeTermValue,
  output logic                     termUseWrite,
  output wlt_pkg::wlt_srt_t        tempRange,
  output logic                     autoTempSwitching,
  output logic [4:0]               writeCasDelay,
  output logic [6:0]               totalWriteDelay,
  output logic                     casCodeInvalid,
  output logic                     reservedSet,
  output logic                     firstDataExpected,
  output logic                     writeBusy
);
  // ***************************************************
  // Types and state
  // ***************************************************
  typedef enum logic [1:0] {WR_IDLE, WR_WAIT, WR_BURST} wlt_wr_t;

  logic [17:0]        mr_r;
  logic [17:0]        mr_nxt;
  wlt_wr_t            wr_r;
  wlt_wr_t            wr_nxt;
  logic [6:0]         cnt_r;
  logic [6:0]         cnt_nxt;
  logic               first_r;
  logic               first_nxt;
  logic               useWr_r;
  logic               useWr_nxt;
  wlt_pkg::wlt_term_t termVal_r;
  wlt_pkg::wlt_term_t termVal_nxt;
  wlt_pkg::wlt_srt_t  srt_r;
  wlt_pkg::wlt_srt_t  srt_nxt;
  logic [4:0]         cas_r;
  logic [4:0]         cas_nxt;
  logic [6:0]         total_r;
  logic [6:0]         total_nxt;
  logic               casBad_r;
  logic               casBad_nxt;
  logic               rsvd_r;
  logic               rsvd_nxt;
  logic [2:0]         termCode;
  logic [2:0]         casCode;
  logic               loadHit;

  // ***************************************************
  // Mode register load
  // ***************************************************
  // Field views of the held register
  assign termCode = mr_r[wlt_pkg::TERM_LSB +: 3];
  assign casCode  = mr_r[wlt_pkg::CAS_LSB +: 3];
  assign loadHit  = link.mrsValid
                    && (link.mrsSelect == wlt_pkg::SEL_SECOND);

  // Replace only on a load aimed at this register
  always_comb
  begin
    mr_nxt = mr_r;
    if (loadHit)
    begin
      mr_nxt = link.mrsAddr;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mr_r <= 18'h0_0000;
    end
    else
    begin
      mr_r <= mr_nxt;
    end
  end

  // ***************************************************
  // Field decode
  // ***************************************************
  // Decoded values follow the held register
  always_comb
  begin
    termVal_nxt = wlt_pkg::wlt_term_dec(termCode);
    srt_nxt     = wlt_pkg::wlt_srt_t'(mr_r[wlt_pkg::SRT_LSB +: 2]);
    cas_nxt     = wlt_pkg::wlt_cas_dec(casCode, link.preamble2);
    // Not-applicable codes under two-clock preamble
    casBad_nxt  = (cas_nxt == 5'h00);
    // Whole-cycle sum, no half-cycle term
    total_nxt   = wlt_pkg::wlt_total(link.addedDelay, link.parityDelay,
                                     cas_nxt);
    // Flag a one in any reserved position
    rsvd_nxt    = |(mr_r & wlt_pkg::RSVD_MASK);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      termVal_r <= wlt_pkg::TERM_NONE;
      srt_r     <= wlt_pkg::SRT_NORMAL;
      cas_r     <= 5'h09;
      total_r   <= 7'h09;
      casBad_r  <= 1'b0;
      rsvd_r    <= 1'b0;
    end
    else
    begin
      termVal_r <= termVal_nxt;
      srt_r     <= srt_nxt;
      cas_r     <= cas_nxt;
      total_r   <= total_nxt;
      casBad_r  <= casBad_nxt;
      rsvd_r    <= rsvd_nxt;
    end
  end

  // ***************************************************
  // Write timing and termination switch
  // ***************************************************
  // Count whole cycles from write command to first data
  always_comb
  begin
    wr_nxt    = wr_r;
    cnt_nxt   = cnt_r;
    first_nxt = 1'b0;
    useWr_nxt = useWr_r;
    unique case (wr_r)
      WR_IDLE:
      begin
        useWr_nxt = 1'b0;
        if (link.writeCmd)
        begin
          wr_nxt  = WR_WAIT;
          cnt_nxt = total_r;
          // Own switch, no load command needed
          useWr_nxt = (termCode != 3'h0)
                      && !link.writeLeveling;
        end
      end
      WR_WAIT:
      begin
        if (cnt_r <= 7'h01)
        begin
          wr_nxt    = WR_BURST;
          first_nxt = 1'b1;
          cnt_nxt   = 7'(wlt_pkg::BURST_CYC);
        end
        else
        begin
          cnt_nxt = cnt_r - 7'h01;
        end
      end
      WR_BURST:
      begin
        if (cnt_r <= 7'h01)
        begin
          wr_nxt    = WR_IDLE;
          useWr_nxt = 1'b0;
        end
        else
        begin
          cnt_nxt = cnt_r - 7'h01;
        end
      end
    endcase
    // Leveling drops write termination on the next edge
    if (link.writeLeveling)
    begin
      useWr_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_r    <= WR_IDLE;
      cnt_r   <= 7'h00;
      first_r <= 1'b0;
      useWr_r <= 1'b0;
    end
    else
    begin
      wr_r    <= wr_nxt;
      cnt_r   <= cnt_nxt;
      first_r <= first_nxt;
      useWr_r <= useWr_nxt;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign writeTermValue    = termVal_r;
  assign termUseWrite      = useWr_r;
  assign tempRange         = srt_r;
  assign autoTempSwitching = (srt_r == wlt_pkg::SRT_AUTO);
  assign writeCasDelay     = cas_r;
  assign totalWriteDelay   = total_r;
  assign casCodeInvalid    = casBad_r;
  assign reservedSet       = rsvd_r;
  assign firstDataExpected = first_r;
  assign writeBusy         = (wr_r != WR_IDLE);
endmodule // wlt_device

// file: core/wlt_controller.sv
/*
  Controller end: AHB-Lite register slave that builds and issues
  loads of the second mode register and forwards write commands.
  Assumes a single AHB-Lite master, zero-wait slave, same clock.
*/
`timescale 1ns/1ns
module wlt_controller (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        writeReq,
  input  wire logic        gearDown,
  input  wire logic        dllOff,
  input  wire logic        levelingReq,
  input  wire logic        preambleTwo,
  wlt_link_if.ctrl         link
);
  // ***************************************************
  // State
  // ***************************************************
  logic [7:0]  cfg_r, cfg_nxt;
  logic [8:0]  lat_r, lat_nxt;
  logic [1:0]  stat_r, stat_nxt;
  logic        mrs_r, mrs_nxt;
  logic [17:0] addr_r, addr_nxt;
  logic        wr_r, wr_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        dWr_r, dWr_nxt;
  logic [7:0]  dAdr_r, dAdr_nxt;
  logic [2:0]  term;
  logic [4:0]  cas;
  logic        bad;

  // Termination with DLL-off override on low bits
  assign term = dllOff ? {cfg_r[7], 2'h0} : cfg_r[7:5];
  assign cas  = wlt_pkg::wlt_cas_dec(cfg_r[2:0], preambleTwo);
  // Refuse forbidden CAS codes
  assign bad  = (cas == 5'h00)
                || (gearDown && !cfg_r[2] && !cfg_r[0]);

  // ***************************************************
  // Bus slave and command issue
  // ***************************************************
  // Address phase capture, data phase write
  always_comb
  begin
    cfg_nxt  = cfg_r;
    lat_nxt  = lat_r;
    stat_nxt = stat_r;
    mrs_nxt  = 1'b0;
    addr_nxt = addr_r;
    wr_nxt   = writeReq;
    rd_nxt   = rd_r;
    dWr_nxt  = 1'b0;
    dAdr_nxt = dAdr_r;
    if (hsel && htrans[1] && hready)
    begin
      dWr_nxt  = hwrite;
      dAdr_nxt = haddr[7:0];
      unique case (haddr[7:0])
        wlt_pkg::OFS_CFG:  rd_nxt = {24'h00_0000, cfg_r};
        wlt_pkg::OFS_LAT:  rd_nxt = {23'h00_0000, lat_r};
        wlt_pkg::OFS_STAT:
          rd_nxt = {23'h00_0000, wlt_pkg::wlt_total(lat_r[8:4], lat_r[3:0],
                    cas), stat_r};
        default:           rd_nxt = 32'h0000_0000;
      endcase
    end
    if (dWr_r)
    begin
      unique case (dAdr_r)
        wlt_pkg::OFS_CFG: cfg_nxt = hwdata[7:0];
        wlt_pkg::OFS_LAT: lat_nxt = hwdata[8:0];
        wlt_pkg::OFS_CMD:
        begin
          if (hwdata[0] && bad)
          begin
            stat_nxt[1] = 1'b1;
          end
          else if (hwdata[0])
          begin
            mrs_nxt  = 1'b1;
            stat_nxt = 2'h1;
            // Reserved bits left zero
            addr_nxt = (18'(term) << wlt_pkg::TERM_LSB)
                       | (18'(cfg_r[4:3]) << wlt_pkg::SRT_LSB)
                       | (18'(cfg_r[2:0]) << wlt_pkg::CAS_LSB);
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_r  <= 8'h00;
      lat_r  <= 9'h000;
      stat_r <= 2'h0;
      mrs_r  <= 1'b0;
      addr_r <= 18'h0_0000;
      wr_r   <= 1'b0;
      rd_r   <= 32'h0000_0000;
      dWr_r  <= 1'b0;
      dAdr_r <= 8'h00;
    end
    else
    begin
      cfg_r  <= cfg_nxt;
      lat_r  <= lat_nxt;
      stat_r <= stat_nxt;
      mrs_r  <= mrs_nxt;
      addr_r <= addr_nxt;
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      dWr_r  <= dWr_nxt;
      dAdr_r <= dAdr_nxt;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = rd_r;
  assign link.mrsValid      = mrs_r;
  assign link.mrsSelect     = wlt_pkg::SEL_SECOND;
  assign link.mrsAddr       = addr_r;
  assign link.writeCmd      = wr_r;
  assign link.writeLeveling = levelingReq;
  assign link.preamble2     = preambleTwo;
  assign link.addedDelay    = lat_r[8:4];
  assign link.parityDelay   = lat_r[3:0];
endmodule // wlt_controller

// file: test/wlt_properties.sv
/*
  Concurrent checks on the link between controller and device ends.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module wlt_properties (
  input wire logic          clk,
  input wire logic          resetn,
  input wire logic          mrsValid,
  input wire logic [2:0]    mrsSelect,
  input wire logic [17:0]   mrsAddr,
  input wire logic          writeCmd,
  input wire logic          writeLeveling,
  input wlt_pkg::wlt_term_t writeTermValue,
  input wlt_pkg::wlt_srt_t  tempRange,
  input wire logic          autoTempSwitching,
  input wire logic          termUseWrite,
  input wire logic          reservedSet,
  input wire logic          firstDataExpected,
  input wire logic          writeBusy,
  input wire logic [6:0]    totalWriteDelay
);
  logic [6:0] cycleCnt_r;
  logic [6:0] cycleCnt_nxt;
  logic [6:0] expDly;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Edges since the edge that took a write, zero while idle
  always_comb
  begin
    cycleCnt_nxt = writeBusy ? cycleCnt_r + 7'h01 : 7'h00;
  end
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cycleCnt_r <= 7'h00;
    else
      cycleCnt_r <= cycleCnt_nxt;
  assign expDly = (totalWriteDelay < 7'h02) ? 7'h01 : totalWriteDelay;

  // ****************************************
  // Assertions
  // ****************************************
  sel_two_a: assert property (mrsValid |-> mrsSelect == 3'h2)
    else $error("load with wrong select");
  load_pulse_a: assert property (mrsValid |=> !mrsValid)
    else $error("load strobe longer than one cycle");
  term_decode_a: assert property (mrsValid && mrsAddr[11:9] <= 3'h4
    |-> ##2 3'(writeTermValue) == mrsAddr[11:9]) else $error("termination decode wrong");
  temp_decode_a: assert property (mrsValid |-> ##2 2'(tempRange) == mrsAddr[7:6]
    && autoTempSwitching == &mrsAddr[7:6]) else $error("temperature decode wrong");
  reserved_flag_a: assert property (mrsValid
    |-> ##2 reservedSet == |(mrsAddr & wlt_pkg::RSVD_MASK)) else $error("reserved flag wrong");
  first_data_a: assert property (cycleCnt_r != 7'h00 && cycleCnt_r <= expDly
    |-> firstDataExpected == (cycleCnt_r == expDly)) else $error("first data at wrong cycle");
  burst_end_a: assert property (firstDataExpected
    |=> writeBusy [*3] ##1 !writeBusy) else $error("write burst length wrong");
  term_switch_a: assert property (writeCmd && !writeBusy && !writeLeveling
    && writeTermValue != wlt_pkg::TERM_NONE |=> termUseWrite) else $error("no termination switch");
  term_zero_a: assert property (termUseWrite |-> writeTermValue != wlt_pkg::TERM_NONE)
    else $error("switch with termination field zero");
  level_nominal_a: assert property (writeLeveling && $past(writeLeveling)
    |-> !termUseWrite) else $error("write termination during leveling");
  fields_hold_a: assert property (!$past(mrsValid) && !$past(mrsValid, 2)
    |-> $stable(writeTermValue) && $stable(tempRange)) else $error("fields changed without load");

  // Main scenarios reached
  load_seen_c: cover property (mrsValid);
  first_data_c: cover property (firstDataExpected);
  level_write_c: cover property (writeLeveling && writeCmd);
endmodule // wlt_properties

// file: test/testbench.sv
/*
  Self-checking bench: AHB master tasks drive the controller, the
  device decodes loads and times writes. Assumes the link package.
*/
`timescale 1ns/1ns
module testbench;
  logic               clk, resetn, hsel, hwrite, hreadyout, writeReq;
  logic               gearDown, dllOff, levelingReq, preambleTwo;
  logic [31:0]        haddr, hwdata, hrdata, q;
  logic [1:0]         htrans;
  wlt_pkg::wlt_term_t termVal;
  wlt_pkg::wlt_srt_t  tempRange;
  logic               termUse, autoTemp, casBad, rsvdSet, firstData, busy, t, refd;
  logic [4:0]         casDly, e, prevCas;
  logic [6:0]         totalDly;
  int                 n, badCount, checkCount;
  logic [4:0]         casTab [8] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h12, 5'h14};
  logic [4:0]         modeTab [5] = '{5'h13, 5'h14, 5'h08, 5'h0A, 5'h09};
  wlt_link_if         link ();

  wlt_controller wlt_controller_i (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .writeReq(writeReq), .gearDown(gearDown), .dllOff(dllOff),
    .levelingReq(levelingReq), .preambleTwo(preambleTwo), .link(link.ctrl));
  wlt_device wlt_device_i (.clk(clk), .resetn(resetn), .link(link.dev),
    .writeTermValue(termVal), .termUseWrite(termUse), .tempRange(tempRange),
    .autoTempSwitching(autoTemp), .writeCasDelay(casDly), .totalWriteDelay(totalDly),
    .casCodeInvalid(casBad), .reservedSet(rsvdSet), .firstDataExpected(firstData),
    .writeBusy(busy));
  wlt_properties wlt_properties_i (.clk(clk), .resetn(resetn), .mrsValid(link.mrsValid),
    .mrsSelect(link.mrsSelect), .mrsAddr(link.mrsAddr), .writeCmd(link.writeCmd),
    .writeLeveling(link.writeLeveling), .writeTermValue(termVal), .tempRange(tempRange),
    .autoTempSwitching(autoTemp), .termUseWrite(termUse), .reservedSet(rsvdSet),
    .firstDataExpected(firstData), .writeBusy(busy), .totalWriteDelay(totalDly));

  // ****************************************
  // Clock, compare and bus tasks
  // ****************************************
  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One single AHB transfer, read data left in q
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask

  // Configure, issue a load, read status
  task automatic load(input logic [31:0] cfg);
    ahb(1'h1, wlt_pkg::OFS_CFG, cfg);
    ahb(1'h1, wlt_pkg::OFS_CMD, 32'h0000_0001);
    repeat (3) @(posedge clk);
    ahb(1'h0, wlt_pkg::OFS_STAT, 32'h0000_0000);
  endtask

  // Issue one write, count cycles to first data
  task automatic wr_time();
    @(posedge clk) writeReq <= 1'h1;
    @(posedge clk) writeReq <= 1'h0;
    @(posedge clk);
    #1 t = termUse;
    n = 0;
    while (firstData !== 1'h1 && n < 60)
    begin
      @(posedge clk);
      #1 n++;
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    {clk, resetn, htrans, hwrite, writeReq, gearDown, dllOff, levelingReq, preambleTwo} = '0;
    {haddr, hwdata} = '0;
    hsel = 1'h1;
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    ahb(1'h1, wlt_pkg::OFS_LAT, 32'h0000_0032);
    ahb(1'h0, wlt_pkg::OFS_LAT, 32'h0000_0000);
    chk("lat", q, 32'h0000_0032);
    ahb(1'h1, 8'h10, 32'hFFFF_FFFF);
    ahb(1'h0, 8'h10, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      load({24'h00_0000, 3'(i), 2'(i), 3'(i)});
      chk("issue", q[1:0], 2'h1);
      chk("total", q[8:2], 7'(casTab[i]) + 7'h05);
      chk("addr", link.mrsAddr, {6'h00, 3'(i), 1'h0, 2'(i), 3'(i), 3'h0});
      chk("term", termVal, (i > 4) ? 32'(wlt_pkg::TERM_RSVD) : 32'(i));
      chk("temp", {autoTemp, tempRange}, {&2'(i), 2'(i)});
      chk("cas", casDly, casTab[i]);
      chk("totaldev", totalDly, 7'(casTab[i]) + 7'h05);
      chk("rsvd", rsvdSet, 1'h0);
    end
    prevCas = casTab[7];
    for (int k = 0; k < 5; k++)
    begin
      e = modeTab[k];
      refd = (e[4] && !e[2]) || (e[3] && !e[2] && !e[0]);
      if (!refd)
        prevCas = casTab[e[2:0]];
      preambleTwo <= e[4];
      gearDown <= e[3];
      load({24'h00_0000, 5'h08, e[2:0]});
      chk("refused", q[1], refd);
      chk("cas2", casDly, prevCas);
      chk("invalid", casBad, 1'h0);
    end
    // Held low code under a later two-clock preamble
    preambleTwo <= 1'h1;
    repeat (3) @(posedge clk);
    chk("invalid2", casBad, 1'h1);
    chk("casna", casDly, 5'h00);
    {preambleTwo, gearDown} <= 2'h0;
    dllOff <= 1'h1;
    load(32'h0000_00A0);
    chk("dll", {link.mrsAddr[11:9], 3'(termVal)}, {3'h4, 3'(wlt_pkg::TERM_80)});
    dllOff <= 1'h0;
    for (int j = 0; j < 3; j++)
    begin
      levelingReq <= (j == 2);
      load((j == 1) ? 32'h0000_0000 : 32'h0000_0020);
      wr_time();
      chk("delay", 32'(n), 32'h0000_000E);
      chk("termuse", t, (j == 0));
      chk("idle", {termUse, busy}, 2'h0);
    end
    end_sim();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (4000) @(posedge clk);
    badCount++;
    end_sim();
  end
endmodule // testbench
